/* File: capture_match_timer.sv */
// Capture/match timer: prescaler, counter, captures, matches, outputs and interrupt
//
// Behaviour
// - Prescale counter counts timer clock ticks; counter advances when it reaches prescale.
// - Prescale limit and timer counter are both full 32-bit values.
// - Four capture channels store the count on a selected edge of their input.
// - Each capture channel has its own enable for raising an interrupt.
// - Four 32-bit match registers are compared continuously with the counter.
// - A match may leave counting running, optionally raising an interrupt.
// - A match may halt the counter, optionally raising an interrupt.
// - A match may clear the counter to zero, optionally raising an interrupt.
// - Each match output goes low, high, toggles or holds on its match.
// - Counting is in timer clock periods; counters step only on that clock, but the reset bit and COUNT writes act on clk_sys.
// - Registers run on the bus clock; counters follow the separate timer clock.
`timescale 1ns/1ps
`include "tmr_consts.svh"
module capture_match_timer import tmr_pkg::*; (
    input  logic                   clk_sys,
    input  logic                   arst_n,
    input  logic                   ce,
    input  logic [`TMR_ADDR_W-1:0] awaddr,
    input  logic                   awvalid,
    output logic                   awready,
    input  logic [31:0]            wdata,
    input  logic [3:0]             wstrb,
    input  logic                   wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  logic                   bready,
    input  logic [`TMR_ADDR_W-1:0] araddr,
    input  logic                   arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  logic                   rready,
    input  logic                   timer_count_clock,
    input  logic [3:0]             capture_input,
    output logic [3:0]             match_output,
    output logic                   irq
);
    tmr_state_t r;
    tmr_state_t n;

    logic                   wr_en;
    logic [`TMR_ADDR_W-1:0] wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;
    logic                   wr_err;
    logic [`TMR_ADDR_W-1:0] rd_addr;
    logic [31:0]            rd_data;
    logic                   rd_err;
    logic [`TMR_SYNC_W-1:0] pin_rise;
    logic [`TMR_SYNC_W-1:0] pin_fall;
    logic                   tick;
    logic                   advance;
    logic [3:0]             match_hit;
    logic [3:0]             match_evt;
    logic [3:0]             cap_evt;
    logic [3:0]             rst_hit;
    logic [3:0]             stop_hit;

    // Byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // True for every offset that answers OKAY
    function automatic logic mapped(input logic [`TMR_ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a[1:0] == 2'b00) begin
            hit = (a <= `TMR_OFS_IRQ_MASK) || (a[7:4] == `TMR_OFS_MATCH_HI) || (a[7:4] == `TMR_OFS_CAPT_HI);
        end
        return hit;
    endfunction

    tmr_axil_slave u_bus (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ce      (ce),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // Timer clock enters as a sampled pin; needs to stay below a quarter of clk_sys
    tmr_pin_sync u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ce      (ce),
        .din     ({timer_count_clock, capture_input}),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    assign tick    = pin_rise[`TMR_CH_N];
    assign advance = r.en && !r.crst && tick && (r.pc == r.pr);
    assign wr_err  = !mapped(wr_addr);
    assign rd_err  = !mapped(rd_addr);

    genvar g;
    generate
        for (g = 0; g < `TMR_CH_N; g++) begin : g_ch
            assign match_hit[g] = (r.tc == r.mr[g]);
            assign match_evt[g] = advance && match_hit[g];
            assign rst_hit[g]   = match_evt[g] && r.mcr[`TMR_FLD_W*g + `TMR_MCR_RST];
            assign stop_hit[g]  = match_evt[g] && r.mcr[`TMR_FLD_W*g + `TMR_MCR_STOP];
            assign cap_evt[g]   = (pin_rise[g] && r.ccr[`TMR_FLD_W*g + `TMR_CCR_RISE]) ||
                                  (pin_fall[g] && r.ccr[`TMR_FLD_W*g + `TMR_CCR_FALL]);
        end
    endgenerate

    always_comb begin
        n = r;
        // Software writes first, hardware events after so that a set wins over a clear
        if (wr_en) begin
            if (wr_addr[7:4] == `TMR_OFS_MATCH_HI) begin
                n.mr[wr_addr[3:2]] = merge(r.mr[wr_addr[3:2]], wr_data, wr_strb);
            end
            case (wr_addr)
                `TMR_OFS_CTRL: begin
                    if (wr_strb[0]) begin
                        n.en   = wr_data[`TMR_CTRL_EN_BIT];
                        n.crst = wr_data[`TMR_CTRL_RST_BIT];
                    end
                end
                `TMR_OFS_COUNT:      n.tc    = merge(r.tc, wr_data, wr_strb);
                `TMR_OFS_PRESCALE:   n.pr    = merge(r.pr, wr_data, wr_strb);
                `TMR_OFS_MATCH_CTRL: n.mcr   = 12'(merge({20'h0_0000, r.mcr}, wr_data, wr_strb));
                `TMR_OFS_CAP_CTRL:   n.ccr   = 12'(merge({20'h0_0000, r.ccr}, wr_data, wr_strb));
                `TMR_OFS_OUT_CTRL: begin
                    if (wr_strb[0]) begin
                        n.mout  = wr_data[`TMR_OUT_STATE_LSB +: 4];
                        n.emode[3:0] = wr_data[`TMR_OUT_MODE_LSB +: 4];
                    end
                    if (wr_strb[1]) begin
                        n.emode[7:4] = wr_data[11:8];
                    end
                end
                `TMR_OFS_IRQ_STATUS: begin
                    if (wr_strb[0]) begin
                        n.ists = r.ists & ~wr_data[7:0];
                    end
                end
                `TMR_OFS_IRQ_MASK: begin
                    if (wr_strb[0]) begin
                        n.imask = wr_data[7:0];
                    end
                end
                default: ;
            endcase
        end
        if (r.crst) begin
            n.tc = `TMR_RST_WORD;
            n.pc = `TMR_RST_WORD;
        end else if (r.en && tick) begin
            if (r.pc == r.pr) begin
                n.pc = `TMR_RST_WORD;
                if (|rst_hit) begin
                    n.tc = `TMR_RST_WORD;
                end else if (|stop_hit) begin
                    n.tc = r.tc;
                end else begin
                    n.tc = r.tc + 32'h1;
                end
                if (|stop_hit) begin
                    n.en = 1'b0;
                end
            end else begin
                n.pc = r.pc + 32'h1;
            end
        end
        for (int i = 0; i < `TMR_CH_N; i++) begin
            if (match_evt[i]) begin
                unique case (out_mode_t'(r.emode[2*i +: 2]))
                    OUT_HOLD:   n.mout[i] = r.mout[i];
                    OUT_LOW:    n.mout[i] = 1'b0;
                    OUT_HIGH:   n.mout[i] = 1'b1;
                    OUT_TOGGLE: n.mout[i] = ~r.mout[i];
                endcase
                if (r.mcr[`TMR_FLD_W*i + `TMR_MCR_INT]) begin
                    n.ists[i] = 1'b1;
                end
            end
            if (cap_evt[i]) begin
                n.cap[i] = r.tc;
                if (r.ccr[`TMR_FLD_W*i + `TMR_CCR_INT]) begin
                    n.ists[`TMR_IRQ_CAP_LSB + i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    always_comb begin
        rd_data = `TMR_RST_WORD;
        if (rd_addr[7:4] == `TMR_OFS_MATCH_HI) begin
            rd_data = r.mr[rd_addr[3:2]];
        end else if (rd_addr[7:4] == `TMR_OFS_CAPT_HI) begin
            rd_data = r.cap[rd_addr[3:2]];
        end else begin
            case (rd_addr)
                `TMR_OFS_CTRL:       rd_data = {30'h0, r.crst, r.en};
                `TMR_OFS_COUNT:      rd_data = r.tc;
                `TMR_OFS_PRESCALE:   rd_data = r.pr;
                `TMR_OFS_PCOUNT:     rd_data = r.pc;
                `TMR_OFS_MATCH_CTRL: rd_data = {20'h0_0000, r.mcr};
                `TMR_OFS_CAP_CTRL:   rd_data = {20'h0_0000, r.ccr};
                `TMR_OFS_OUT_CTRL:   rd_data = {20'h0_0000, r.emode, r.mout};
                `TMR_OFS_IRQ_STATUS: rd_data = {24'h00_0000, r.ists};
                `TMR_OFS_IRQ_MASK:   rd_data = {24'h00_0000, r.imask};
                default:             rd_data = `TMR_RST_WORD;
            endcase
        end
    end

    assign match_output = r.mout;
    assign irq          = |(r.ists & r.imask);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_prescale_step: assert property (ce && r.en && !r.crst && tick && r.pc != r.pr
        && !(wr_en && wr_addr == `TMR_OFS_COUNT) |=> r.pc == $past(r.pc) + 32'h1 && r.tc == $past(r.tc))
        else $error("prescale counter did not step alone");
    chk_count_advance: assert property (ce && advance && !(|match_hit)
        && !(wr_en && wr_addr == `TMR_OFS_COUNT) |=> r.tc == $past(r.tc) + 32'h1 && r.pc == 32'h0)
        else $error("counter did not advance on prescale wrap");
    chk_capture_store: assert property (ce && cap_evt[0] |=> r.cap[0] == $past(r.tc))
        else $error("capture did not store the count");
    chk_capture_irq: assert property (ce && cap_evt[0] && r.ccr[`TMR_CCR_INT]
        |=> r.ists[`TMR_IRQ_CAP_LSB] && (r.imask[`TMR_IRQ_CAP_LSB] -> irq))
        else $error("capture flag not raised");
    chk_match_flag: assert property (ce && match_evt[0] && r.mcr[`TMR_MCR_INT] |=> r.ists[0])
        else $error("match flag not raised");
    chk_match_stop: assert property (ce && stop_hit[0] && !(|rst_hit)
        |=> !r.en && r.tc == $past(r.tc) ##1 (!ce || !r.en || r.tc == $past(r.tc)))
        else $error("stop on match failed");
    chk_match_reset: assert property (ce && rst_hit[0] |=> r.tc == 32'h0)
        else $error("reset on match failed");
    chk_out_toggle: assert property (ce && match_evt[0] && r.emode[1:0] == OUT_TOGGLE
        |=> match_output[0] != $past(match_output[0]))
        else $error("match output did not toggle");
    chk_match_compare: assert property (ce && advance && r.tc != r.mr[0]
        && !(wr_en && wr_addr == `TMR_OFS_OUT_CTRL) |=> match_output[0] == $past(match_output[0]))
        else $error("match output moved without equal count");
    chk_only_on_tick: assert property (ce && !tick && !r.crst && !(wr_en && wr_addr == `TMR_OFS_COUNT)
        |=> r.tc == $past(r.tc) && r.pc == $past(r.pc))
        else $error("counter moved without timer clock edge");
    chk_flag_clear: assert property (ce && wr_en && wr_addr == `TMR_OFS_IRQ_STATUS && wr_strb[0]
        && wr_data[0] && !match_evt[0] |=> !r.ists[0]
        ##1 (!r.ists[0] || ($past(match_evt[0]) && $past(r.mcr[`TMR_MCR_INT]))))
        else $error("flag not cleared by write of one");
endmodule // capture_match_timer

/* File: capture_match_timer_tb.sv */
// Self-checking bench of the capture/match timer
`timescale 1ns/1ps
`include "tmr_consts.svh"
module capture_match_timer_tb_top import tmr_pkg::*;;
    logic        clk_sys, arst_n, ce, timer_count_clock;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb, capture_input, match_output;
    logic [1:0]  bresp, rresp;
    int          mismatches, n_tests, cyc;

    capture_match_timer capture_match_timer_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_count_clock(timer_count_clock), .capture_input(capture_input),
        .match_output(match_output), .irq(irq));

    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Timer clock at 1/8 of the bus clock, edges on bus clock falling edges, clear of rising edges
    initial begin
        timer_count_clock = 0;
        forever #80 timer_count_clock = ~timer_count_clock;
    end

    task test_done;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Ready sampled at the falling edge, released after the rising edge that took it
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, aw_d, w_d, hit;
        logic [1:0] rs;
        aw_d = 0;
        w_d = 0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(negedge clk_sys);
            ah = awready && !aw_d;
            wh = wready && !w_d;
            @(posedge clk_sys);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            aw_d |= ah;
            w_d |= wh;
        end
        do begin
            @(negedge clk_sys);
            hit = bvalid;
            rs = bresp;
            @(posedge clk_sys);
        end while (!hit);
        bready <= 1'b0;
        chk("bresp", {30'h0, rs}, {30'h0, er});
    endtask

    task automatic axr(input logic [7:0] a, input logic [1:0] er);
        logic hit;
        logic [1:0] rs;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            hit = arready;
            @(posedge clk_sys);
        end while (!hit);
        arvalid <= 1'b0;
        do begin
            @(negedge clk_sys);
            hit = rvalid;
            rs = rresp;
            rd = rdata;
            @(posedge clk_sys);
        end while (!hit);
        rready <= 1'b0;
        chk("rresp", {30'h0, rs}, {30'h0, er});
    endtask

    task automatic t_regs;
        axr(`TMR_OFS_CTRL, `TMR_RESP_OKAY);
        chk("ctrl reset", rd, `TMR_RST_WORD);
        axw(`TMR_OFS_PRESCALE, 32'ha5a5_5a5a, `TMR_RESP_OKAY);
        axr(`TMR_OFS_PRESCALE, `TMR_RESP_OKAY);
        chk("prescale", rd, 32'ha5a5_5a5a);
        axw(`TMR_OFS_PCOUNT, 32'h0000_0077, `TMR_RESP_OKAY);
        axr(`TMR_OFS_PCOUNT, `TMR_RESP_OKAY);
        chk("pcount ro", rd, 32'h0000_0000);
        axw(8'h80, 32'h0000_0001, `TMR_RESP_DECERR);
        axr(8'h80, `TMR_RESP_DECERR);
        chk("unmapped", rd, 32'h0000_0000);
        $display("test regs done");
    endtask

    // Prescale 1: count advances every second tick, halts at match 5
    task automatic t_stop;
        axw(`TMR_OFS_PRESCALE, 32'h0000_0001, `TMR_RESP_OKAY);
        axw(8'h30, 32'h0000_0005, `TMR_RESP_OKAY);
        axw(`TMR_OFS_MATCH_CTRL, 32'h0000_0005, `TMR_RESP_OKAY);
        axw(`TMR_OFS_IRQ_MASK, 32'h0000_0001, `TMR_RESP_OKAY);
        axw(`TMR_OFS_CTRL, 32'h0000_0001, `TMR_RESP_OKAY);
        repeat (60) @(posedge clk_sys);
        axr(`TMR_OFS_COUNT, `TMR_RESP_OKAY);
        chk("count mid", {31'h0, rd < 32'd5}, 32'h1);
        repeat (150) @(posedge clk_sys);
        axr(`TMR_OFS_COUNT, `TMR_RESP_OKAY);
        chk("count stop", rd, 32'h0000_0005);
        axr(`TMR_OFS_CTRL, `TMR_RESP_OKAY);
        chk("run cleared", rd & 32'h1, 32'h0);
        chk("irq", {31'h0, irq}, 32'h1);
        axw(`TMR_OFS_IRQ_STATUS, 32'h0000_00ff, `TMR_RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        chk("irq clr", {31'h0, irq}, 32'h0);
        $display("test stop done");
    endtask

    // Match 1 at 3 clears the counter and drives output 1 high
    task automatic t_reset;
        logic m0;
        axw(`TMR_OFS_PRESCALE, 32'h0000_0000, `TMR_RESP_OKAY);
        axw(`TMR_OFS_COUNT, 32'h0000_0000, `TMR_RESP_OKAY);
        axw(8'h34, 32'h0000_0003, `TMR_RESP_OKAY);
        axw(`TMR_OFS_MATCH_CTRL, 32'h0000_0018, `TMR_RESP_OKAY);
        axw(`TMR_OFS_OUT_CTRL, 32'h0000_0080, `TMR_RESP_OKAY);
        axw(`TMR_OFS_CTRL, 32'h0000_0001, `TMR_RESP_OKAY);
        repeat (120) @(posedge clk_sys);
        chk("out1 high", {28'h0, match_output}, 32'h2);
        axr(`TMR_OFS_COUNT, `TMR_RESP_OKAY);
        chk("count wraps", {31'h0, rd <= 32'd3}, 32'h1);
        axr(`TMR_OFS_CTRL, `TMR_RESP_OKAY);
        chk("still run", rd & 32'h1, 32'h1);
        axr(`TMR_OFS_IRQ_STATUS, `TMR_RESP_OKAY);
        chk("m1 flag", rd & 32'h3, 32'h2);
        chk("masked", {31'h0, irq}, 32'h0);
        // Match 0 at 3 toggles output 0 once per 32-cycle lap
        axw(8'h30, 32'h0000_0003, `TMR_RESP_OKAY);
        axw(`TMR_OFS_OUT_CTRL, 32'h0000_00b2, `TMR_RESP_OKAY);
        @(posedge clk_sys);
        m0 = match_output[0];
        repeat (32) @(posedge clk_sys);
        chk("out0 toggle", {31'h0, match_output[0]}, {31'h0, ~m0});
        axw(`TMR_OFS_CTRL, 32'h0000_0000, `TMR_RESP_OKAY);
        $display("test reset done");
    endtask

    task automatic t_capture;
        axw(`TMR_OFS_COUNT, 32'h0000_1234, `TMR_RESP_OKAY);
        axw(`TMR_OFS_IRQ_STATUS, 32'h0000_00ff, `TMR_RESP_OKAY);
        axw(`TMR_OFS_CAP_CTRL, 32'h0000_0140, `TMR_RESP_OKAY);
        axw(`TMR_OFS_IRQ_MASK, 32'h0000_0040, `TMR_RESP_OKAY);
        @(posedge clk_sys);
        capture_input <= 4'h4;
        repeat (8) @(posedge clk_sys);
        axr(8'h48, `TMR_RESP_OKAY);
        chk("capture2", rd, 32'h0000_1234);
        chk("cap irq", {31'h0, irq}, 32'h1);
        axw(`TMR_OFS_IRQ_STATUS, 32'h0000_0040, `TMR_RESP_OKAY);
        axr(`TMR_OFS_IRQ_STATUS, `TMR_RESP_OKAY);
        chk("cap flag clr", rd, 32'h0);
        chk("irq low", {31'h0, irq}, 32'h0);
        $display("test capture done");
    endtask

    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        ce = 1'b1;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        capture_input = 4'h0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_regs();
        t_stop();
        t_reset();
        t_capture();
        test_done();
    end
endmodule // capture_match_timer_tb_top

/* File: tmr_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_axil_slave import tmr_pkg::*; (
    input  logic                   clk_sys,
    input  logic                   arst_n,
    input  logic                   ce,
    input  logic [`TMR_ADDR_W-1:0] awaddr,
    input  logic                   awvalid,
    output logic                   awready,
    input  logic [31:0]            wdata,
    input  logic [3:0]             wstrb,
    input  logic                   wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  logic                   bready,
    input  logic [`TMR_ADDR_W-1:0] araddr,
    input  logic                   arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  logic                   rready,
    output logic                   wr_en,
    output logic [`TMR_ADDR_W-1:0] wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  logic                   wr_err,
    output logic [`TMR_ADDR_W-1:0] rd_addr,
    input  logic [31:0]            rd_data,
    input  logic                   rd_err
);
    axil_state_t r;
    axil_state_t n;

    // AW, W and AR handshakes stall while ce is low, so no beat is lost
    assign awready = ce && !r.aw_got && !r.bvalid;
    assign wready  = ce && !r.w_got && !r.bvalid;
    assign arready = ce && !r.rvalid;
    assign wr_en   = ce && r.aw_got && r.w_got && !r.bvalid;

    always_comb begin
        n = r;
        if (awvalid && awready) begin
            n.aw_got = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (wr_en) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = wr_err ? `TMR_RESP_DECERR : `TMR_RESP_OKAY;
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_data;
            n.rresp  = rd_err ? `TMR_RESP_DECERR : `TMR_RESP_OKAY;
        end
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign wr_addr = r.awaddr;
    assign wr_data = r.wdata;
    assign wr_strb = r.wstrb;
    assign rd_addr = araddr;
    assign bvalid  = r.bvalid;
    assign bresp   = r.bresp;
    assign rvalid  = r.rvalid;
    assign rdata   = r.rdata;
    assign rresp   = r.rresp;
endmodule // tmr_axil_slave

/* File: tmr_consts.svh */
// Register map, field positions, reset values and bus codes of the capture/match timer
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define TMR_ADDR_W          8
`define TMR_CH_N            4
`define TMR_SYNC_W          5

`define TMR_OFS_CTRL        8'h00
`define TMR_OFS_COUNT       8'h04
`define TMR_OFS_PRESCALE    8'h08
`define TMR_OFS_PCOUNT      8'h0c
`define TMR_OFS_MATCH_CTRL  8'h10
`define TMR_OFS_CAP_CTRL    8'h14
`define TMR_OFS_OUT_CTRL    8'h18
`define TMR_OFS_IRQ_STATUS  8'h1c
`define TMR_OFS_IRQ_MASK    8'h20
`define TMR_OFS_MATCH_HI    4'h3
`define TMR_OFS_CAPT_HI     4'h4

`define TMR_CTRL_EN_BIT     0
`define TMR_CTRL_RST_BIT    1

`define TMR_FLD_W           3
`define TMR_MCR_INT         0
`define TMR_MCR_RST         1
`define TMR_MCR_STOP        2
`define TMR_CCR_RISE        0
`define TMR_CCR_FALL        1
`define TMR_CCR_INT         2

`define TMR_OUT_STATE_LSB   0
`define TMR_OUT_MODE_LSB    4
`define TMR_IRQ_CAP_LSB     4

`define TMR_RST_WORD        32'h0000_0000
`define TMR_RESP_OKAY       2'b00
`define TMR_RESP_DECERR     2'b11

`endif

/* File: tmr_pin_sync.sv */
// Two-stage pin synchroniser with rise and fall detection
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_pin_sync import tmr_pkg::*; (
    input  logic                   clk_sys,
    input  logic                   arst_n,
    input  logic                   ce,
    input  logic [`TMR_SYNC_W-1:0] din,
    output logic [`TMR_SYNC_W-1:0] rise,
    output logic [`TMR_SYNC_W-1:0] fall
);
    sync_state_t r;
    sync_state_t n;

    always_comb begin
        n    = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    // Only s2/s3 are looked at; s1 may be metastable
    assign rise = r.s2 & ~r.s3;
    assign fall = ~r.s2 & r.s3;

    chk_sync_two_stage: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && $past(ce) && $past(ce, 2) && $past(ce, 3) && rise[0] |-> $past(din[0], 2) && !$past(din[0], 3))
        else $error("edge reported without two-stage delay");
endmodule // tmr_pin_sync

/* File: tmr_pkg.sv */
// Types shared by the capture/match timer modules
package tmr_pkg;
`include "tmr_consts.svh"

    typedef enum logic [1:0] {
        OUT_HOLD   = 2'b00,
        OUT_LOW    = 2'b01,
        OUT_HIGH   = 2'b10,
        OUT_TOGGLE = 2'b11
    } out_mode_t;

    typedef struct packed {
        logic        en;
        logic        crst;
        logic [31:0] tc;
        logic [31:0] pc;
        logic [31:0] pr;
        logic [3:0][31:0] mr;
        logic [3:0][31:0] cap;
        logic [11:0] mcr;
        logic [11:0] ccr;
        logic [3:0]  mout;
        logic [7:0]  emode;
        logic [7:0]  ists;
        logic [7:0]  imask;
    } tmr_state_t;

    typedef struct packed {
        logic                  aw_got;
        logic [`TMR_ADDR_W-1:0] awaddr;
        logic                  w_got;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } axil_state_t;

    typedef struct packed {
        logic [`TMR_SYNC_W-1:0] s1;
        logic [`TMR_SYNC_W-1:0] s2;
        logic [`TMR_SYNC_W-1:0] s3;
    } sync_state_t;
endpackage
